/* hw/rtc_params.svh */
// register map, field positions, reset values and timing constants for the rtc core
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
`define CLK_HZ 200000000
`define CLK_PERIOD_NS 5
`define XTAL_HZ 32768
`define XTAL_STEP (2 * `XTAL_HZ)
`define PHASE_W 28
`define PRE_W 15
`define PRE_MAX 15'h7fff
`define P4096_MASK 15'h0007
`define P64_MASK 15'h01ff
`define P1024_BIT 4
`define P32_BIT 9
`define P1_BIT 14
`define BUSY_NS 122000
`define ADJ_MAX_NS 244000
`define BUSY_TICKS ((64'd122000 * 64'd32768 + 64'd999999999) / 64'd1000000000)
`define TIRQ_FAST_NS 122000
`define TIRQ_SLOW_NS 7810000
`define TPULSE_W 21
`define ADDR_W 6
`define BANK_TIME 2'h0
`define BANK_ALARM 2'h1
`define BANK_TIMER 2'h2
`define R_SEC_T 4'h1
`define R_WDAY 4'h6
`define R_ALARM_LAST 4'h8
`define R_LINK 4'hb
`define R_DIV_LO 4'hc
`define R_DIV_HI 4'hd
`define R_TIME_LAST 4'hd
`define R_YEAR_K 4'he
`define R_COMMON 4'he
`define R_CTRL 4'hf
`define R_DT_LO 4'h0
`define R_DT_HI 4'h1
`define R_PRE_LO 4'h4
`define R_PRE_HI 4'h5
`define R_CNT_LO 4'h6
`define R_CNT_HI 4'h7
`define R_TSET 4'h8
`define FLAG_BIT 1
`define IE_BIT 0
`define FOS_BIT 3
`define MASK_BIT 3
`define ADJ_BIT 0
`define STOP_BIT 1
`define SEC_LAST 8'h59
`define HOUR_LAST 8'h23
`define MON_LAST 8'h12
`define YEAR_LAST 8'h99
`define WDAY_LAST 3'h6
`define BCD_ZERO 8'h00
`define BCD_ONE 8'h01
`define BCD_NINE 4'h9
`define HALF_MIN 8'h30
`define RST_DATE_U 4'h1
`define RST_FOS 1'b1
`endif

/* hw/rtc_pkg.sv */
// shared types for the rtc core
`include "rtc_params.svh"
package rtc_pkg;
    typedef struct packed {
        logic read;
        logic write;
        logic [`ADDR_W-1:0] address;
        logic [31:0] writedata;
    } avs_req_t;
    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avs_rsp_t;
    typedef struct packed {
        logic out;
        logic oe_n;
    } od_pin_t;
    typedef struct packed {
        logic [7:0] val;
        logic wrap;
    } bcd_step_t;
endpackage

/* hw/rtc_core.sv */
// rtc core: bcd calendar, alarm, countdown timer, frequency output and avalon register slave
`include "rtc_params.svh"
module rtc_core #(
    parameter int TIRQ_FAST_CYC = `TIRQ_FAST_NS / `CLK_PERIOD_NS,
    parameter int TIRQ_SLOW_CYC = `TIRQ_SLOW_NS / `CLK_PERIOD_NS
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire rtc_pkg::avs_req_t avs_req,
    output rtc_pkg::avs_rsp_t avs_rsp,
    input wire logic osc_low_detect,
    input wire logic chip_select_high_pin,
    input wire logic freq_out_mode_pin,
    output rtc_pkg::od_pin_t irq_pin,
    output rtc_pkg::od_pin_t fout_pin,
    output logic sensor_run,
    output logic pace_adjust_run
);
    import rtc_pkg::*;

    // bcd increment with wrap to a first value
    function automatic bcd_step_t bcd_inc(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
        bcd_step_t r;
        r.wrap = (v == last);
        r.val = r.wrap ? first : (v[3:0] == `BCD_NINE) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
        return r;
    endfunction

    // two-digit bcd year divisible by four; good for the whole 1901..2099 span
    function automatic logic is_leap(input logic [7:0] y);
        return y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    endfunction

    function automatic logic [7:0] month_last(input logic [7:0] m, input logic leap);
        if (m == 8'h02) begin
            return leap ? 8'h29 : 8'h28;
        end
        return (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) ? 8'h30 : 8'h31;
    endfunction

    // divider length and high-phase length per divider code
    function automatic logic [9:0] div_shape(input logic [2:0] sel);
        case (sel)
            3'h0: return {5'd1, 5'd1};
            3'h1: return {5'd2, 5'd1};
            3'h2: return {5'd3, 5'd1};
            3'h3: return {5'd6, 5'd3};
            3'h4: return {5'd5, 5'd1};
            3'h5: return {5'd10, 5'd5};
            3'h6: return {5'd15, 5'd5};
            default: return {5'd30, 5'd15};
        endcase
    endfunction

    logic wait_q, stop_q, adj_q, test_q, temp_q, fos_q, af_q, aie_q, tf_q, tie_q;
    logic te_q, rep_q, fe_q, ck32_q, src_prev_q, chk_q, irq_oe_n_q, fout_q, fout_oe_n_q;
    logic sensor_q, pace_q;
    logic [1:0] bank_q, link_q, fsrc_q, tsrc_q;
    logic [2:0] divl_q;
    logic [3:0] rd, rdata_q;
    logic [4:0] fdiv_q;
    logic [7:0] dt_q, pre_q, cnt_q;
    logic [`PRE_W-1:0] presc_q;
    logic [`PHASE_W-1:0] phase_q;
    logic [`TPULSE_W-1:0] tpulse_q;
    logic [3:0] tm_q [0:14];
    logic [3:0] tm_d [0:14];
    logic [3:0] al_q [0:8];

    // bus decode; a write lands on the edge where waitrequest is seen low
    wire req = avs_req.read | avs_req.write;
    wire wr = avs_req.write & ~wait_q;
    wire [3:0] idx = avs_req.address[5:2];
    wire [3:0] wd = avs_req.writedata[3:0];
    wire wr_b0 = wr && bank_q == `BANK_TIME;
    wire wr_b1 = wr && bank_q == `BANK_ALARM;
    wire wr_b2 = wr && bank_q == `BANK_TIMER;
    wire wr_ctrl = wr && idx == `R_CTRL;
    wire wr_comm = wr && idx == `R_COMMON;
    wire wr_tset = wr_b2 && idx == `R_TSET;
    wire pre_wr = wr_b2 && (idx == `R_PRE_LO || idx == `R_PRE_HI);
    wire [7:0] pre_new = (idx == `R_PRE_LO) ? {pre_q[7:4], wd} : {wd, pre_q[3:0]};

    // crystal-rate phase accumulator: ck32_q is the 32.768 khz square wave
    wire [`PHASE_W:0] phase_sum = {1'b0, phase_q} + (`PHASE_W+1)'(`XTAL_STEP);
    wire half = phase_sum >= (`PHASE_W+1)'(`CLK_HZ);
    wire xtal_tick = half & ~ck32_q;
    wire run_tick = xtal_tick & ~stop_q;
    wire [`PRE_W-1:0] busy_n = `PRE_W'(`BUSY_TICKS);
    wire busy = presc_q > (`PRE_MAX - busy_n) || presc_q < busy_n;
    wire adj_fire = adj_q & xtal_tick;
    wire upd = (run_tick && presc_q == `PRE_MAX) || adj_fire;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= '0;
            ck32_q <= 1'b0;
            presc_q <= '0;
        end else begin
            phase_q <= half ? `PHASE_W'(phase_sum - (`PHASE_W+1)'(`CLK_HZ)) : phase_sum[`PHASE_W-1:0];
            ck32_q <= ck32_q ^ half;
            presc_q <= adj_fire ? '0 : run_tick ? presc_q + 1'b1 : presc_q;
        end
    end

    // calendar chain; a bus write in the same cycle wins over the update
    bcd_step_t s, mi, h, d, mo, yl, yh;
    wire [7:0] sec_v = {1'b0, tm_q[1][2:0], tm_q[0]};
    wire [7:0] yl_v = {tm_q[12], tm_q[11]};
    always_comb begin
        for (int i = 0; i < 15; i++) begin
            tm_d[i] = tm_q[i];
        end
        s = bcd_inc(sec_v, `SEC_LAST, `BCD_ZERO);
        if (adj_fire) begin
            s.val = `BCD_ZERO;
            s.wrap = sec_v >= `HALF_MIN;
        end
        mi = bcd_inc({tm_q[3], tm_q[2]}, `SEC_LAST, `BCD_ZERO);
        h = bcd_inc({tm_q[5], tm_q[4]}, `HOUR_LAST, `BCD_ZERO);
        d = bcd_inc({tm_q[8], tm_q[7]}, month_last({tm_q[10], tm_q[9]}, is_leap(yl_v)), `BCD_ONE);
        mo = bcd_inc({tm_q[10], tm_q[9]}, `MON_LAST, `BCD_ONE);
        yl = bcd_inc(yl_v, `YEAR_LAST, `BCD_ZERO);
        yh = bcd_inc({tm_q[14], tm_q[13]}, `YEAR_LAST, `BCD_ZERO);
        if (upd) begin
            {tm_d[1], tm_d[0]} = s.val;
            if (s.wrap) begin
                {tm_d[3], tm_d[2]} = mi.val;
            end
            if (s.wrap && mi.wrap) begin
                {tm_d[5], tm_d[4]} = h.val;
            end
            if (s.wrap && mi.wrap && h.wrap) begin
                tm_d[`R_WDAY] = (tm_q[`R_WDAY][2:0] == `WDAY_LAST) ? 4'h0 : tm_q[`R_WDAY] + 4'h1;
                {tm_d[8], tm_d[7]} = d.val;
                if (d.wrap) begin
                    {tm_d[10], tm_d[9]} = mo.val;
                end
                if (d.wrap && mo.wrap) begin
                    {tm_d[12], tm_d[11]} = yl.val;
                end
                if (d.wrap && mo.wrap && yl.wrap) begin
                    {tm_d[14], tm_d[13]} = yh.val;
                end
            end
        end
        if (wr_b0 && idx <= `R_TIME_LAST) begin
            tm_d[idx] = wd;
        end else if (wr_b0 && idx == `R_YEAR_K) begin
            tm_d[`R_YEAR_K] = {2'b00, wd[1:0]};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 15; i++) begin
                tm_q[i] <= (i == 7 || i == 9) ? `RST_DATE_U : 4'h0;
            end
        end else begin
            for (int i = 0; i < 15; i++) begin
                tm_q[i] <= tm_d[i];
            end
        end
    end

    // alarm comparison runs the cycle after a seconds update that is not an adjust, on the new time
    wire m_sec = al_q[1][`MASK_BIT] || {al_q[1][2:0], al_q[0]} == sec_v[6:0];
    wire m_min = al_q[3][`MASK_BIT] || {al_q[3][2:0], al_q[2]} == {tm_q[3][2:0], tm_q[2]};
    wire m_hr = al_q[5][`MASK_BIT] || {al_q[5][1:0], al_q[4]} == {tm_q[5][1:0], tm_q[4]};
    wire m_wd = al_q[6][`MASK_BIT] || al_q[6][2:0] == tm_q[`R_WDAY][2:0];
    wire m_day = al_q[8][`MASK_BIT] || {al_q[8][1:0], al_q[7]} == {tm_q[8][1:0], tm_q[7]};
    wire alarm_hit = chk_q && m_sec && m_min && m_hr && m_wd && m_day;
    wire af_clr = wr_b1 && wr_comm && !wd[`FLAG_BIT];
    wire fos_clr = wr_b0 && idx == `R_SEC_T && !wd[`FOS_BIT];

    // timer source select and zero event
    wire [3:0] tsrc_ticks = {upd && s.wrap, upd, run_tick && (presc_q & `P64_MASK) == `P64_MASK,
                             run_tick && (presc_q & `P4096_MASK) == `P4096_MASK};
    wire tsrc_tick = tsrc_ticks[tsrc_q];
    wire tzero = te_q && tsrc_tick && cnt_q == 8'h01;
    wire tf_clr = wr_b2 && wr_comm && !wd[`FLAG_BIT];
    wire tirq_act = tie_q && (rep_q ? tpulse_q != '0 : tf_q);
    wire irq_act = (af_q && aie_q) || tirq_act;

    // flags: hardware set wins over a clearing write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fos_q <= `RST_FOS;
            af_q <= 1'b0;
            tf_q <= 1'b0;
            chk_q <= 1'b0;
            irq_oe_n_q <= 1'b1;
        end else begin
            fos_q <= osc_low_detect | (fos_q & ~fos_clr);
            af_q <= alarm_hit | (af_q & ~af_clr);
            tf_q <= tzero | (tf_q & ~tf_clr);
            chk_q <= upd && !adj_fire;
            irq_oe_n_q <= ~irq_act;
        end
    end

    // down counter, run bit and repeat-mode release timer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= '0;
            cnt_q <= '0;
            te_q <= 1'b0;
            tpulse_q <= '0;
        end else begin
            if (pre_wr) begin
                pre_q <= pre_new;
                cnt_q <= pre_new;
            end else if (tzero) begin
                cnt_q <= rep_q ? pre_q : 8'h00;
            end else if (te_q && tsrc_tick && cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end
            te_q <= wr_tset ? wd[3] : (te_q & ~(tzero & ~rep_q));
            if (tzero && rep_q) begin
                tpulse_q <= (tsrc_q == 2'h0) ? `TPULSE_W'(TIRQ_FAST_CYC) : `TPULSE_W'(TIRQ_SLOW_CYC);
            end else if (tpulse_q != '0) begin
                tpulse_q <= tpulse_q - 1'b1;
            end
        end
    end

    // software-owned settings and the adjust request, which clears itself when it fires
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 9; i++) begin
                al_q[i] <= 4'h0;
            end
            {bank_q, stop_q, adj_q, test_q, temp_q, aie_q, tie_q} <= '0;
            {rep_q, tsrc_q, link_q, divl_q, fe_q, fsrc_q, dt_q} <= '0;
        end else begin
            if (wr_b1 && idx <= `R_ALARM_LAST) begin
                al_q[idx] <= wd;
            end
            if (wr_ctrl) begin
                {bank_q, stop_q} <= wd[3:1];
            end
            adj_q <= (wr_ctrl & wd[`ADJ_BIT]) | (adj_q & ~adj_fire);
            if (wr_comm && bank_q != 2'h3) begin
                {test_q, temp_q} <= wd[3:2];
            end
            if (wr_b1 && wr_comm) begin
                aie_q <= wd[`IE_BIT];
            end
            if (wr_b2 && wr_comm) begin
                tie_q <= wd[`IE_BIT];
            end
            if (wr_tset) begin
                {rep_q, tsrc_q} <= wd[2:0];
            end
            if (wr_b1 && idx == `R_LINK) begin
                link_q <= wd[3:2];
            end
            if (wr_b1 && idx == `R_DIV_LO) begin
                divl_q <= wd[2:0];
            end
            if (wr_b1 && idx == `R_DIV_HI) begin
                {fe_q, fsrc_q} <= {wd[3], wd[1:0]};
            end
            if (wr_b2 && idx == `R_DT_LO) begin
                dt_q[3:0] <= wd;
            end
            if (wr_b2 && idx == `R_DT_HI) begin
                dt_q[7:4] <= wd;
            end
        end
    end

    // frequency output: divider counts rising edges of the chosen source
    wire [3:0] fsrc_levels = {presc_q[`P1_BIT], presc_q[`P32_BIT], presc_q[`P1024_BIT], ck32_q};
    wire fsrc = fsrc_levels[fsrc_q];
    wire [9:0] shape = div_shape(divl_q);
    wire fdiv_last = fdiv_q >= shape[9:5] - 5'd1;
    wire fdiv_out = (shape[9:5] == 5'd1) ? fsrc : fdiv_q < shape[4:0];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_prev_q <= 1'b0;
            fdiv_q <= '0;
            fout_q <= 1'b0;
            fout_oe_n_q <= 1'b1;
            sensor_q <= 1'b0;
            pace_q <= 1'b0;
        end else begin
            src_prev_q <= fsrc;
            if (fsrc && !src_prev_q) begin
                fdiv_q <= fdiv_last ? 5'd0 : fdiv_q + 5'd1;
            end
            fout_q <= freq_out_mode_pin ? fdiv_out : ck32_q;
            fout_oe_n_q <= freq_out_mode_pin & ~fe_q;
            sensor_q <= temp_q && (link_q[1] || chip_select_high_pin);
            pace_q <= dt_q[7] && (link_q[0] || chip_select_high_pin);
        end
    end

    // register read mux, unused slots read zero
    always_comb begin
        rd = 4'h0;
        if (idx == `R_CTRL) begin
            rd = {bank_q, stop_q, busy};
        end else if (bank_q == `BANK_TIME) begin
            rd = (idx == `R_SEC_T) ? {fos_q, tm_q[1][2:0]} : (idx == `R_YEAR_K) ? {test_q, temp_q, tm_q[14][1:0]} : tm_q[idx];
        end else if (bank_q == `BANK_ALARM) begin
            case (idx)
                `R_LINK: rd = {link_q, 2'b00};
                `R_DIV_LO: rd = {1'b0, divl_q};
                `R_DIV_HI: rd = {fe_q, 1'b0, fsrc_q};
                `R_COMMON: rd = {test_q, temp_q, af_q, aie_q};
                default: rd = (idx <= `R_ALARM_LAST) ? al_q[idx] : 4'h0;
            endcase
        end else if (bank_q == `BANK_TIMER) begin
            case (idx)
                `R_DT_LO: rd = dt_q[3:0];
                `R_DT_HI: rd = dt_q[7:4];
                `R_PRE_LO: rd = pre_q[3:0];
                `R_PRE_HI: rd = pre_q[7:4];
                `R_CNT_LO: rd = cnt_q[3:0];
                `R_CNT_HI: rd = cnt_q[7:4];
                `R_TSET: rd = {te_q, rep_q, tsrc_q};
                `R_COMMON: rd = {test_q, temp_q, tf_q, tie_q};
                default: rd = 4'h0;
            endcase
        end
    end

    // one wait cycle per access keeps the read mux off the critical path
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
            rdata_q <= 4'h0;
        end else begin
            wait_q <= ~(req & wait_q);
            if (avs_req.read && wait_q) begin
                rdata_q <= rd;
            end
        end
    end

    assign avs_rsp = '{readdata: {28'h000_0000, rdata_q}, waitrequest: wait_q};
    assign irq_pin = '{out: 1'b0, oe_n: irq_oe_n_q};
    assign fout_pin = '{out: fout_q, oe_n: fout_oe_n_q};
    assign sensor_run = sensor_q;
    assign pace_adjust_run = pace_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_wait; req && wait_q |=> !wait_q ##1 wait_q; endproperty
    a_wait: assert property (p_wait) else $error("waitrequest not released for one cycle");
    property p_hour_wrap; upd && sec_v == `SEC_LAST && {tm_q[3], tm_q[2]} == `SEC_LAST
        && {tm_q[5], tm_q[4]} == `HOUR_LAST && !wr |=> {tm_q[5], tm_q[4]} == `BCD_ZERO; endproperty
    a_hour_wrap: assert property (p_hour_wrap) else $error("hour did not wrap to 00");
    property p_fos; osc_low_detect |=> fos_q; endproperty
    a_fos: assert property (p_fos) else $error("oscillator-low flag not set");
    property p_af_hold; af_q && !af_clr |=> af_q; endproperty
    a_af_hold: assert property (p_af_hold) else $error("alarm flag lost");
    property p_alarm; upd && !adj_fire ##1 (m_sec && m_min && m_hr && m_wd && m_day) |=> af_q; endproperty
    a_alarm: assert property (p_alarm) else $error("alarm match missed");
    property p_irq; (af_q && aie_q) || (tf_q && tie_q && !rep_q) |=> !irq_pin.oe_n; endproperty
    a_irq: assert property (p_irq) else $error("interrupt pin not pulled low");
    property p_irq_off; !(af_q && aie_q) && !tie_q |=> irq_pin.oe_n; endproperty
    a_irq_off: assert property (p_irq_off) else $error("disabled interrupt reached pin");
    property p_oneshot; tzero && !rep_q && !pre_wr && !wr_tset |=> !te_q && cnt_q == 8'h00 && tf_q; endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot timer did not stop at zero");
    property p_repeat; tzero && rep_q && !pre_wr |=> cnt_q == $past(pre_q) && tpulse_q != '0; endproperty
    a_repeat: assert property (p_repeat) else $error("repeat timer did not reload");
    property p_fout_z; freq_out_mode_pin && !fe_q |=> fout_pin.oe_n; endproperty
    a_fout_z: assert property (p_fout_z) else $error("frequency output not floated");
    // helper: cycles the adjust request has stood; one crystal tick is far inside the bound
    logic [15:0] adj_age_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            adj_age_q <= '0;
        end else begin
            adj_age_q <= adj_q ? adj_age_q + 16'h0001 : 16'h0000;
        end
    end
    property p_adj; adj_q |-> adj_age_q < 16'(`ADJ_MAX_NS / `CLK_PERIOD_NS); endproperty
    a_adj: assert property (p_adj) else $error("adjust request not cleared");
    c_alarm: cover property (alarm_hit && aie_q);
    c_repeat: cover property (tzero && rep_q ##1 tpulse_q != '0);
    c_adj: cover property (adj_fire && sec_v >= `HALF_MIN);
endmodule

/* testbench/avs_host.sv */
// avalon-mm host model that issues single register accesses to the rtc core
module avs_host (
    input wire logic ref_clk,
    output rtc_pkg::avs_req_t avs_req,
    input wire rtc_pkg::avs_rsp_t avs_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_pkg::*;
    // idle bus from time zero, so nothing is seen as a request during reset
    initial avs_req = '0;
    // one access: raised after an edge, held until waitrequest is sampled low, released only then
    task automatic access(input logic wr, input logic [3:0] idx, input logic [3:0] d, output logic [3:0] q);
        @(posedge ref_clk);
        avs_req <= '{read: !wr, write: wr, address: {idx, 2'h0}, writedata: {28'h000_0000, d}};
        do @(posedge ref_clk); while (avs_rsp.waitrequest !== 1'b0);
        q = avs_rsp.readdata[3:0];
        avs_req <= '0;
    endtask
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the rtc core: register table, pins, oscillator flag and countdown timer
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_pkg::*;
    logic ref_clk, rst_n, osc_low_detect, chip_select_high_pin, freq_out_mode_pin, sensor_run, pace_adjust_run;
    avs_req_t avs_req;
    avs_rsp_t avs_rsp;
    od_pin_t irq_pin, fout_pin;
    int num_errors = 0;
    int checks_done = 0;
    int cnt;
    logic [3:0] q;
    logic old;
    // rows are {bank, index, write data, expected read}
    logic [15:0] rows [8] = '{16'h0666, 16'h0522, 16'h1bcc, 16'h1c77, 16'h1d99, 16'h1e31, 16'h22f0, 16'h26f0};
    // time digits 0..12: 23:59:59, saturday, 28 february, year 24 (leap)
    logic [3:0] cal [13] = '{4'h9, 4'h5, 4'h9, 4'h5, 4'h3, 4'h2, 4'h6, 4'h8, 4'h2, 4'h2, 4'h0, 4'h4, 4'h2};

    // release windows shortened so repeat-mode pulses stay short
    rtc_core #(.TIRQ_FAST_CYC(20), .TIRQ_SLOW_CYC(50)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .avs_req(avs_req), .avs_rsp(avs_rsp), .osc_low_detect(osc_low_detect),
        .chip_select_high_pin(chip_select_high_pin), .freq_out_mode_pin(freq_out_mode_pin),
        .irq_pin(irq_pin), .fout_pin(fout_pin), .sensor_run(sensor_run), .pace_adjust_run(pace_adjust_run));
    avs_host host (.ref_clk(ref_clk), .avs_req(avs_req), .avs_rsp(avs_rsp));

    // 200 mhz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic wr(input logic [3:0] i, input logic [3:0] d);
        host.access(1'b1, i, d, q);
    endtask
    task automatic chk_reg(input logic [3:0] got, input logic [3:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [3:0] i, input logic [3:0] exp);
        host.access(1'b0, i, 4'h0, q);
        chk_reg(q, exp);
    endtask
    // clocks from one change of the frequency output to the next
    task automatic half_period(output int n);
        old = fout_pin.out;
        for (int k = 0; k < 7000 && fout_pin.out === old; k++) @(posedge ref_clk);
        old = fout_pin.out;
        n = 0;
        while (n < 7000 && fout_pin.out === old) begin
            @(posedge ref_clk);
            n++;
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog sized for the 4096 hz timer wait, the adjust wait, two output periods and register traffic
    initial begin
        #450000;
        num_errors++;
        complete_run();
    end

    initial begin
        rst_n = 1'b0;
        osc_low_detect = 1'b0;
        chip_select_high_pin = 1'b0;
        freq_out_mode_pin = 1'b1;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_chk(4'h7, 4'h1);
        rd_chk(4'h1, 4'h8);
        $display("done: reset values");
        // bank select first, then write and read back each row
        foreach (rows[n]) begin
            wr(4'hf, {rows[n][13:12], 2'h0});
            wr(rows[n][11:8], rows[n][7:4]);
            rd_chk(rows[n][11:8], rows[n][3:0]);
        end
        chk_pin(irq_pin.oe_n, 1'b1);
        $display("done: register table");
        wr(4'hf, 4'h4);
        chk_pin(fout_pin.oe_n, 1'b0);
        wr(4'hd, 4'h1);
        repeat (2) @(posedge ref_clk);
        chk_pin(fout_pin.oe_n, 1'b1);
        freq_out_mode_pin <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk_pin(fout_pin.oe_n, 1'b0);
        // half period of the raw crystal output is about 3052 clocks
        half_period(cnt);
        chk_pin(cnt inside {[2900:3200]}, 1'b1);
        // programmable output: 32768 hz source divided by two, about 6104 clocks per half period
        freq_out_mode_pin <= 1'b1;
        wr(4'hd, 4'h8);
        wr(4'hc, 4'h1);
        half_period(cnt);
        chk_pin(cnt inside {[5900:6300]}, 1'b1);
        chk_pin(fout_pin.oe_n, 1'b0);
        $display("done: frequency output");
        wr(4'hf, 4'h0);
        wr(4'h1, 4'h0);
        rd_chk(4'h1, 4'h0);
        osc_low_detect <= 1'b1;
        @(posedge ref_clk);
        osc_low_detect <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd_chk(4'h1, 4'h8);
        $display("done: oscillator flag");
        wr(4'hf, 4'h4);
        wr(4'hb, 4'h0);
        wr(4'he, 4'h4);
        wr(4'hf, 4'h8);
        wr(4'h1, 4'h8);
        repeat (2) @(posedge ref_clk);
        chk_pin(sensor_run, 1'b0);
        chk_pin(pace_adjust_run, 1'b0);
        chip_select_high_pin <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk_pin(sensor_run, 1'b1);
        chk_pin(pace_adjust_run, 1'b1);
        chip_select_high_pin <= 1'b0;
        wr(4'hf, 4'h4);
        wr(4'hb, 4'hc);
        repeat (2) @(posedge ref_clk);
        chk_pin(sensor_run, 1'b1);
        chk_pin(pace_adjust_run, 1'b1);
        $display("done: pin links");
        // 30-second adjust from 23:59:59 carries through minute, hour, weekday and leap day
        wr(4'hf, 4'h0);
        foreach (cal[k]) begin
            wr(4'(k), cal[k]);
        end
        wr(4'hf, 4'h1);
        // the adjust waits for the next crystal tick, at most about 6104 clocks
        repeat (6200) @(posedge ref_clk);
        rd_chk(4'hf, 4'h1);
        rd_chk(4'h0, 4'h0);
        rd_chk(4'h1, 4'h0);
        rd_chk(4'h3, 4'h0);
        rd_chk(4'h4, 4'h0);
        rd_chk(4'h5, 4'h0);
        rd_chk(4'h6, 4'h0);
        rd_chk(4'h7, 4'h9);
        rd_chk(4'h8, 4'h2);
        rd_chk(4'h9, 4'h2);
        $display("done: calendar rollover");
        // one-shot countdown from 1 at 4096 hz with the timer interrupt enabled
        wr(4'hf, 4'h8);
        wr(4'h4, 4'h1);
        wr(4'h5, 4'h0);
        wr(4'he, 4'h5);
        wr(4'h8, 4'h8);
        for (int k = 0; k < 60000 && irq_pin.oe_n !== 1'b0; k++) @(posedge ref_clk);
        chk_pin(irq_pin.oe_n, 1'b0);
        rd_chk(4'he, 4'h7);
        rd_chk(4'h8, 4'h0);
        rd_chk(4'h6, 4'h0);
        wr(4'he, 4'h5);
        repeat (2) @(posedge ref_clk);
        chk_pin(irq_pin.oe_n, 1'b1);
        $display("done: countdown timer");
        complete_run();
    end
endmodule
